//--- include/rrc_defines.vh
// Shared constants of the reset and regulator control block.
`ifndef RRC_DEFINES_VH
`define RRC_DEFINES_VH

`define RRC_CLK_NS 50
`define RRC_HOLD_NS 1000
`define RRC_HOLD_CYC ((`RRC_HOLD_NS + `RRC_CLK_NS - 1) / `RRC_CLK_NS)
`define RRC_PIN_LOW_NS 2000
`define RRC_PIN_LOW_CYC ((`RRC_PIN_LOW_NS + `RRC_CLK_NS - 1) / `RRC_CLK_NS)
`define RRC_SYNC_ONLY_CYC 1

`define RRC_ADDR_PROTECT 8'h00
`define RRC_ADDR_REGCTRL 8'h04
`define RRC_ADDR_SLOWOSC 8'h08
`define RRC_ADDR_RSTCTRL 8'h0C
`define RRC_ADDR_SOFTRST 8'h10

`define RRC_PROTECT_KEY_FIELD_KEY 16'h0096
`define RRC_PROTECT_KEY_FIELD_RESET 16'h0000

`define RRC_SEL_BIT 0
`define RRC_DIS_BIT 1
`define RRC_MODE_LSB 4
`define RRC_MODE_MSB 5
`define RRC_STOP_BIT 8
`define RRC_ECO_BIT 9
`define RRC_DISON_BIT 10
`define RRC_SEL_RESET 1'b1
`define RRC_DIS_RESET 1'b0
`define RRC_MODE_AUTO 2'h0
`define RRC_MODE_ECO 2'h1
`define RRC_MODE_NORMAL 2'h2

`define RRC_WAIT_MSB 1
`define RRC_WAIT_RESET 2'h0

`define RRC_KEYEN_BIT 0
`define RRC_SVDEN_BIT 1
`define RRC_WDTRST_BIT 2
`define RRC_CPUREQ_BIT 3
`define RRC_KEYSEL_LSB 4
`define RRC_KEYSEL_MSB 7

`define RRC_KEY_PINS 4
`define RRC_SOFT_CH 8
`define RRC_MEN_RST_MASK 8'h0F

`define RRC_STOP_INTERNAL_OSCILLATOR 16'h1000
`define RRC_WAIT_SEL0 16'h0004
`define RRC_WAIT_SEL1 16'h0010
`define RRC_WAIT_SEL2 16'h0040
`define RRC_WAIT_SEL3 16'h0100

`endif

//--- verilog/rrc_level_filter.v
// Three-stage synchroniser with a minimum-duration level filter.
`include "rrc_defines.vh"

module rrc_level_filter #(
	parameter [7:0] LEN = 8'h01
) (
	input wire clk_sys,
	input wire srst,
	input wire rawIn,
	output reg levelOut
);

	reg sync1_r;
	reg sync2_r;
	reg sync3_r;
	reg [7:0] cnt_r;

	// The level counts only once the second and third stages agree.
	always @(posedge clk_sys) begin
		if (srst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			cnt_r <= 8'h00;
			levelOut <= 1'b0;
		end else begin
			sync1_r <= rawIn;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (sync2_r != sync3_r) begin
				cnt_r <= 8'h00;
			end else if (!sync3_r) begin
				cnt_r <= 8'h00;
				levelOut <= 1'b0;
			end else if (cnt_r < LEN) begin
				cnt_r <= cnt_r + 8'h01;
				if (cnt_r == LEN - 8'h01) begin
					levelOut <= 1'b1;
				end
			end
		end
	end

endmodule // rrc_level_filter

//--- verilog/rrc_clock_stop.v
// Timer that holds the system clock stopped after a voltage-mode switch.
`include "rrc_defines.vh"

module rrc_clock_stop (
	input wire clk_sys,
	input wire srst,
	input wire startPulse,
	input wire slowSrc,
	input wire [`RRC_WAIT_MSB:0] waitSel,
	input wire srcTick,
	output reg stopActive
);

	reg [15:0] target_r;
	reg [15:0] cnt_r;

	function [15:0] slowWait;
		input [`RRC_WAIT_MSB:0] sel;
		begin
			case (sel)
				2'h0: slowWait = `RRC_WAIT_SEL0;
				2'h1: slowWait = `RRC_WAIT_SEL1;
				2'h2: slowWait = `RRC_WAIT_SEL2;
				default: slowWait = `RRC_WAIT_SEL3;
			endcase
		end
	endfunction

	always @(posedge clk_sys) begin
		if (srst) begin
			target_r <= 16'h0000;
			cnt_r <= 16'h0000;
			stopActive <= 1'b0;
		end else if (startPulse) begin
			target_r <= slowSrc ? slowWait(waitSel) : `RRC_STOP_INTERNAL_OSCILLATOR;
			cnt_r <= 16'h0000;
			stopActive <= 1'b1;
		end else if (stopActive && srcTick) begin
			cnt_r <= cnt_r + 16'h0001;
			if (cnt_r == target_r - 16'h0001) begin
				stopActive <= 1'b0;
			end
		end
	end

endmodule // rrc_clock_stop

//--- verilog/rrc_reset_regulator.v
// Regulator mode control and system reset controller with an Avalon-MM slave.
// Notes on behaviour
// - Voltage-mode change stops system clock; internal oscillator source waits 4096 cycles.
// - With the 32 kHz crystal source, the stop lasts the programmed wait count.
// - Key 0x0096 unlocks protection; any other key value relocks it.
// - Voltage select 0 picks low-power mode1, 1 picks default mode0.
// - Operation mode 0x2 forces normal, 0x0 selects automatic.
// - Discharge bit set discharges output while switching toward the lower voltage.
// - Automatic mode switches normal and economy from the light-load indication.
// - Reset is held while supply or oscillator is reported unstable.
// - Reset pin is filtered against short pulses and has a pull-up.
// - Reset pin held low long enough raises a system reset request.
// - Power-on and brown-out detectors raise reset requests.
// - CPU writing 1 to its reset request bit raises a system reset.
// - Enabled key-entry pins held low long enough raise a reset request.
// - Watchdog overflow in reset mode raises a system reset request.
// - Enabled supply voltage detector raises reset on a supply drop.
// - Module enable set on channels 0-3, or a soft reset bit, initialises that peripheral.
// - Hard reset stays asserted for a hold time after requests end.
// - Soft reset group releases immediately when its request is withdrawn.
//
// The Avalon-MM register port and the address map were left to the implementer.
`include "rrc_defines.vh"

module rrc_reset_regulator (
	input wire clk_sys,
	input wire srst,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output wire waitrequest,
	output reg [31:0] readdata,
	input wire resetPinN,
	output wire resetPinPullUp,
	input wire powerOnDetect,
	input wire brownOutDetect,
	input wire supplyUnstable,
	input wire oscUnstable,
	input wire [`RRC_KEY_PINS-1:0] keyPinN,
	input wire watchdogOverflow,
	input wire supplyDropDetect,
	input wire [`RRC_SOFT_CH-1:0] moduleEnable,
	input wire slowOscIsSysClk,
	input wire srcClkTick,
	input wire lightLoad,
	output wire sysClkStop,
	output reg voltageModeLow,
	output reg regEconomy,
	output reg regDischargeOn,
	output reg hardResetOut,
	output reg [`RRC_SOFT_CH-1:0] softResetOut
);

	localparam integer HOLD_INT = `RRC_HOLD_CYC;
	localparam integer PIN_LOW_INT = `RRC_PIN_LOW_CYC;
	localparam integer SYNC_INT = `RRC_SYNC_ONLY_CYC;
	localparam [7:0] HOLD_CYC = HOLD_INT[7:0];
	localparam [7:0] PIN_LOW_CYC = PIN_LOW_INT[7:0];
	localparam [7:0] SYNC_CYC = SYNC_INT[7:0];

	reg ack_r;
	reg [15:0] protKey_r;
	reg voltSel_r;
	reg discharge_r;
	reg [1:0] opMode_r;
	reg [`RRC_WAIT_MSB:0] slowWait_r;
	reg [7:0] rstCtrl_r;
	reg [`RRC_SOFT_CH-1:0] softBits_r;
	reg [`RRC_SOFT_CH-1:0] modEnPrev_r;
	reg cpuReq_r;
	reg [7:0] holdCnt_r;
	reg stopStart_r;
	reg [31:0] readNxt;
	reg [31:0] ctrlNew;
	reg [31:0] keyNew;

	wire accept;
	wire unlocked;
	wire pinLowHeld;
	wire porSync;
	wire borSync;
	wire supplyBad;
	wire oscBad;
	wire svdSync;
	wire [`RRC_KEY_PINS-1:0] keyLowHeld;
	wire [`RRC_KEY_PINS-1:0] keySel;
	wire keyReq;
	wire hardReq;
	wire stopActive;

	function [31:0] laneMerge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0] be;
		reg [31:0] mask;
		begin
			mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			laneMerge = (oldVal & ~mask) | (newVal & mask);
		end
	endfunction

	// One wait cycle per access; the request is taken at the edge where waitrequest is low.
	assign waitrequest = (read | write) & ~ack_r;
	assign accept = (read | write) & ack_r;
	assign unlocked = (protKey_r == `RRC_PROTECT_KEY_FIELD_KEY);
	assign resetPinPullUp = 1'b1;
	assign sysClkStop = stopActive;

	always @(posedge clk_sys) begin
		if (srst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (read | write) & ~ack_r;
		end
	end

	always @* begin
		readNxt = 32'h0000_0000;
		case (address)
			`RRC_ADDR_PROTECT: readNxt[0] = unlocked;
			`RRC_ADDR_REGCTRL: begin
				readNxt[`RRC_SEL_BIT] = voltSel_r;
				readNxt[`RRC_DIS_BIT] = discharge_r;
				readNxt[`RRC_MODE_MSB:`RRC_MODE_LSB] = opMode_r;
				readNxt[`RRC_STOP_BIT] = stopActive;
				readNxt[`RRC_ECO_BIT] = regEconomy;
				readNxt[`RRC_DISON_BIT] = regDischargeOn;
			end
			`RRC_ADDR_SLOWOSC: readNxt[`RRC_WAIT_MSB:0] = slowWait_r;
			`RRC_ADDR_RSTCTRL: readNxt[7:0] = rstCtrl_r;
			`RRC_ADDR_SOFTRST: readNxt[`RRC_SOFT_CH-1:0] = softBits_r;
			default: readNxt = 32'h0000_0000;
		endcase
	end

	always @* begin
		ctrlNew = laneMerge({26'h000_0000, opMode_r, 2'h0, discharge_r, voltSel_r},
			writedata, byteenable);
		keyNew = laneMerge({16'h0000, protKey_r}, writedata, byteenable);
	end

	// Data is loaded during the wait cycle so it stands at the accepting edge.
	always @(posedge clk_sys) begin
		if (srst) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack_r) begin
			readdata <= readNxt;
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			protKey_r <= `RRC_PROTECT_KEY_FIELD_RESET;
			voltSel_r <= `RRC_SEL_RESET;
			discharge_r <= `RRC_DIS_RESET;
			opMode_r <= `RRC_MODE_AUTO;
			slowWait_r <= `RRC_WAIT_RESET;
			rstCtrl_r <= 8'h00;
			softBits_r <= {`RRC_SOFT_CH{1'b0}};
			cpuReq_r <= 1'b0;
			stopStart_r <= 1'b0;
		end else begin
			cpuReq_r <= 1'b0;
			stopStart_r <= 1'b0;
			if (accept && write) begin
				case (address)
					`RRC_ADDR_PROTECT: begin
						protKey_r <= keyNew[15:0];
					end
					`RRC_ADDR_REGCTRL: begin
						if (unlocked) begin
							voltSel_r <= ctrlNew[`RRC_SEL_BIT];
							discharge_r <= ctrlNew[`RRC_DIS_BIT];
							opMode_r <= ctrlNew[`RRC_MODE_MSB:`RRC_MODE_LSB];
							stopStart_r <= (ctrlNew[`RRC_SEL_BIT] != voltSel_r);
						end
					end
					`RRC_ADDR_SLOWOSC: begin
						if (byteenable[0]) begin
							slowWait_r <= writedata[`RRC_WAIT_MSB:0];
						end
					end
					`RRC_ADDR_RSTCTRL: begin
						if (byteenable[0]) begin
							rstCtrl_r <= {writedata[7:4], 1'b0, writedata[2:0]};
							cpuReq_r <= writedata[`RRC_CPUREQ_BIT];
						end
					end
					`RRC_ADDR_SOFTRST: begin
						if (byteenable[0]) begin
							softBits_r <= writedata[`RRC_SOFT_CH-1:0];
						end
					end
					default: begin
						protKey_r <= protKey_r;
					end
				endcase
			end
		end
	end

	rrc_clock_stop u_stop (
		.clk_sys(clk_sys),
		.srst(srst),
		.startPulse(stopStart_r),
		.slowSrc(slowOscIsSysClk),
		.waitSel(slowWait_r),
		.srcTick(srcClkTick),
		.stopActive(stopActive)
	);

	// Regulator outputs are registered from the control bits, lightLoad and the clock stop.
	always @(posedge clk_sys) begin
		if (srst) begin
			voltageModeLow <= 1'b0;
			regEconomy <= 1'b0;
			regDischargeOn <= 1'b0;
		end else begin
			voltageModeLow <= ~voltSel_r;
			regDischargeOn <= discharge_r & stopActive & ~voltSel_r;
			case (opMode_r)
				`RRC_MODE_AUTO: regEconomy <= lightLoad;
				`RRC_MODE_NORMAL: regEconomy <= 1'b0;
				`RRC_MODE_ECO: regEconomy <= 1'b1;
				default: regEconomy <= 1'b0;
			endcase
		end
	end

	rrc_level_filter #(.LEN(PIN_LOW_CYC)) u_pin (
		.clk_sys(clk_sys),
		.srst(srst),
		.rawIn(~resetPinN),
		.levelOut(pinLowHeld)
	);

	rrc_level_filter #(.LEN(SYNC_CYC)) u_por (
		.clk_sys(clk_sys),
		.srst(srst),
		.rawIn(powerOnDetect),
		.levelOut(porSync)
	);

	rrc_level_filter #(.LEN(SYNC_CYC)) u_bor (
		.clk_sys(clk_sys),
		.srst(srst),
		.rawIn(brownOutDetect),
		.levelOut(borSync)
	);

	rrc_level_filter #(.LEN(SYNC_CYC)) u_sup (
		.clk_sys(clk_sys),
		.srst(srst),
		.rawIn(supplyUnstable),
		.levelOut(supplyBad)
	);

	rrc_level_filter #(.LEN(SYNC_CYC)) u_osc (
		.clk_sys(clk_sys),
		.srst(srst),
		.rawIn(oscUnstable),
		.levelOut(oscBad)
	);

	rrc_level_filter #(.LEN(SYNC_CYC)) u_svd (
		.clk_sys(clk_sys),
		.srst(srst),
		.rawIn(supplyDropDetect),
		.levelOut(svdSync)
	);

	genvar k;
	generate
		for (k = 0; k < `RRC_KEY_PINS; k = k + 1) begin : g_key
			rrc_level_filter #(.LEN(PIN_LOW_CYC)) u_key (
				.clk_sys(clk_sys),
				.srst(srst),
				.rawIn(~keyPinN[k]),
				.levelOut(keyLowHeld[k])
			);
		end
	endgenerate

	// Key entry fires when every selected pin is held low.
	assign keySel = rstCtrl_r[`RRC_KEYSEL_MSB:`RRC_KEYSEL_LSB];
	assign keyReq = rstCtrl_r[`RRC_KEYEN_BIT] & (|keySel)
		& ((keyLowHeld & keySel) == keySel);

	assign hardReq = pinLowHeld
		| porSync | borSync
		| cpuReq_r
		| keyReq
		| (watchdogOverflow & rstCtrl_r[`RRC_WDTRST_BIT])
		| (svdSync & rstCtrl_r[`RRC_SVDEN_BIT])
		| supplyBad | oscBad;

	always @(posedge clk_sys) begin
		if (srst) begin
			holdCnt_r <= 8'h00;
			hardResetOut <= 1'b1;
		end else if (hardReq) begin
			holdCnt_r <= 8'h00;
			hardResetOut <= 1'b1;
		end else if (hardResetOut) begin
			holdCnt_r <= holdCnt_r + 8'h01;
			if (holdCnt_r == HOLD_CYC - 8'h01) begin
				hardResetOut <= 1'b0;
			end
		end
	end

	// Soft group: a held bit or a rising module enable on channels 0-3; released without hold.
	always @(posedge clk_sys) begin
		if (srst) begin
			modEnPrev_r <= {`RRC_SOFT_CH{1'b0}};
			softResetOut <= {`RRC_SOFT_CH{1'b0}};
		end else begin
			modEnPrev_r <= moduleEnable;
			softResetOut <= softBits_r
				| (moduleEnable & ~modEnPrev_r & `RRC_MEN_RST_MASK);
		end
	end

endmodule // rrc_reset_regulator

//--- bench/rrc_reset_regulator_asserts.sv
// Port checker for the reset and regulator control block.
module rrc_reset_regulator_asserts (
	input wire clk_sys,
	input wire srst,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire waitrequest,
	input wire powerOnDetect,
	input wire supplyUnstable,
	input wire [7:0] moduleEnable,
	input wire srcClkTick,
	input wire sysClkStop,
	input wire voltageModeLow,
	input wire regDischargeOn,
	input wire hardResetOut,
	input wire [7:0] softResetOut
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk_sys);
endclocking
default disable iff (srst);
logic [12:0] tickCnt_r;
wire quiet = !powerOnDetect && !supplyUnstable;
wire regAcc = write && !waitrequest && address == 8'h04;
always @(posedge clk_sys) begin
	if (srst || !sysClkStop)
		tickCnt_r <= 13'h0;
	else if (srcClkTick)
		tickCnt_r <= tickCnt_r + 13'h1;
end
bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest || !(read || write))
	else $error("waitrequest held past one cycle");
por_reset_a: assert property (powerOnDetect [*6] |-> hardResetOut)
	else $error("power-on request gave no reset");
unstable_hold_a: assert property (supplyUnstable [*6] |-> hardResetOut)
	else $error("reset not held while unstable");
hold_time_a: assert property ($fell(hardResetOut) |-> $past(quiet, 18))
	else $error("reset released before hold time");
cpu_req_a: assert property (regAcc == 0 && write && !waitrequest && address == 8'h0C
	&& writedata[3] |-> ##[1:4] hardResetOut)
	else $error("cpu request gave no reset");
soft_pulse_a: assert property ($rose(moduleEnable[2]) |=> softResetOut[2])
	else $error("module enable gave no soft reset");
stop_cause_a: assert property ($rose(sysClkStop) |-> $past(regAcc, 2))
	else $error("clock stop without control write");
stop_len_a: assert property ($fell(sysClkStop) |->
	tickCnt_r inside {[4094:4097], [2:5], [14:17], [62:65], [254:257]})
	else $error("clock stop length wrong");
dis_cond_a: assert property (regDischargeOn |-> $past(sysClkStop) && voltageModeLow)
	else $error("discharge outside a switch to mode1");
cover property ($rose(sysClkStop));
cover property ($fell(hardResetOut));
cover property (regDischargeOn);
endmodule // rrc_reset_regulator_asserts
bind rrc_reset_regulator rrc_reset_regulator_asserts i_rrc_reset_regulator_asserts (.clk_sys,
	.srst, .address, .read, .write, .writedata, .waitrequest, .powerOnDetect, .supplyUnstable,
	.moduleEnable, .srcClkTick, .sysClkStop, .voltageModeLow, .regDischargeOn, .hardResetOut,
	.softResetOut);

//--- bench/rrc_src_model.sv
// Clock source tick and reset pin model seen by the block.
module rrc_src_model (
	input wire clk_sys,
	input wire slow,
	input wire pinLow,
	output logic srcClkTick,
	output wire resetPinN
);
timeunit 1ns;
timeprecision 1ns;
logic [1:0] div_r = 2'h0;
initial srcClkTick = 1'b0;
// The pin sits on a pull-up, so a released driver reads high.
assign resetPinN = pinLow ? 1'b0 : 1'b1;
always @(posedge clk_sys) begin
	div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
	srcClkTick <= !slow || div_r == 2'h2;
end
endmodule // rrc_src_model

//--- bench/rrc_reset_regulator_tb.sv
// Self-checking bench for the reset and regulator control block.
`include "rrc_defines.vh"
module rrc_reset_regulator_tb;
timeunit 1ns;
timeprecision 1ns;
logic clk_sys = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, slowOscIsSysClk = 1'b0;
logic lightLoad = 1'b0, slow = 1'b0, seen;
logic waitrequest, resetPinPullUp, srcClkTick, sysClkStop, voltageModeLow, regEconomy;
logic regDischargeOn, hardResetOut, resetPinN;
logic [7:0] address = 8'h00, moduleEnable = 8'h00, softResetOut, src = 8'h00;
logic [3:0] byteenable = 4'hF, ksel = 4'hF;
logic [31:0] writedata = 32'h0000_0000, readdata, rd;
int fails = 0, compares = 0, i, n, c;
wire [3:0] keyPinN = src[7] ? ~ksel : 4'hF;
rrc_reset_regulator i_rrc_reset_regulator (.clk_sys, .srst, .address, .read, .write, .writedata,
	.byteenable, .waitrequest, .readdata, .resetPinN, .resetPinPullUp, .powerOnDetect(src[0]),
	.brownOutDetect(src[1]), .supplyUnstable(src[2]), .oscUnstable(src[3]), .keyPinN,
	.watchdogOverflow(src[5]), .supplyDropDetect(src[4]), .moduleEnable, .slowOscIsSysClk,
	.srcClkTick, .lightLoad, .sysClkStop, .voltageModeLow, .regEconomy, .regDischargeOn,
	.hardResetOut, .softResetOut);
rrc_src_model i_rrc_src_model (.clk_sys, .slow, .pinLow(src[6]), .srcClkTick, .resetPinN);
initial forever #25 clk_sys = ~clk_sys;
task automatic final_report();
	$display("compares %0d fails %0d", compares, fails);
	if (fails == 0 && compares > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
	compares++;
	if (s !== e) begin
		fails++;
		$display("[ERR] %s expected %h seen %h", nm, e, s);
	end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	int k;
	@(posedge clk_sys);
	address <= a;
	writedata <= d;
	write <= w;
	read <= !w;
	k = 0;
	do begin
		@(posedge clk_sys);
		k++;
	end while (waitrequest !== 1'b0 && k < 20);
	rd = readdata;
	read <= 1'b0;
	write <= 1'b0;
	if (k >= 20) begin
		fails++;
		final_report();
	end
endtask
task automatic hold(input int cyc, inout logic any);
	repeat (cyc) begin
		@(negedge clk_sys);
		any |= hardResetOut;
	end
	@(posedge clk_sys);
endtask
task automatic relwait(output int cnt);
	cnt = 0;
	while (hardResetOut !== 1'b0 && cnt < 200) begin
		@(negedge clk_sys);
		cnt++;
	end
	if (cnt >= 200) begin
		fails++;
		final_report();
	end
endtask
// Starts a voltage-mode switch and counts source ticks while the clock is held.
task automatic vswitch(input logic [31:0] d, input int e);
	bus(1'b1, `RRC_ADDR_REGCTRL, d);
	repeat (3) @(negedge clk_sys);
	chk("stop", sysClkStop, 1);
	chk("vmode", voltageModeLow, !d[0]);
	chk("dis", regDischargeOn, d[1] & !d[0]);
	n = 2;
	c = 0;
	while (sysClkStop === 1'b1 && c < 20000) begin
		@(negedge clk_sys);
		n += srcClkTick;
		c++;
	end
	if (c >= 20000) begin
		fails++;
		final_report();
	end
	chk("ticks", n >= e - 2 && n <= e + 2, 1);
endtask
initial begin
	void'($urandom(25547));
	repeat (12) @(posedge clk_sys);
	srst <= 1'b0;
	relwait(c);
	chk("hold", c >= 19 && c <= 26, 1);
	chk("pullup", resetPinPullUp, 1);
	bus(1'b0, `RRC_ADDR_REGCTRL, 32'h0000_0000);
	chk("regctrl", rd, 32'h0000_0001);
	bus(1'b0, 8'h20, 32'h0000_0000);
	chk("unmapped", rd, 32'h0000_0000);
	bus(1'b1, `RRC_ADDR_REGCTRL, 32'h0000_0020);
	bus(1'b0, `RRC_ADDR_REGCTRL, 32'h0000_0000);
	chk("locked", rd, 32'h0000_0001);
	bus(1'b1, `RRC_ADDR_PROTECT, `RRC_PROTECT_KEY_FIELD_KEY);
	bus(1'b0, `RRC_ADDR_PROTECT, 32'h0000_0000);
	chk("unlock", rd, 32'h0000_0001);
	for (i = 0; i < 8; i++) begin
		@(posedge clk_sys);
		lightLoad <= 1'($urandom);
		bus(1'b1, `RRC_ADDR_REGCTRL, 32'h0000_0001 | (i % 4) << 4);
		repeat (2) @(negedge clk_sys);
		chk("eco", regEconomy, i % 4 == 1 || (i % 4 == 0 && lightLoad));
	end
	// Module enables stay low through every voltage-mode switch.
	vswitch(32'h0000_0022, 4096);
	bus(1'b1, `RRC_ADDR_REGCTRL, 32'h0000_0000);
	slowOscIsSysClk <= 1'b1;
	slow <= 1'b1;
	for (i = 0; i < 4; i++) begin
		bus(1'b1, `RRC_ADDR_SLOWOSC, i);
		vswitch(i % 2 ? 32'h0000_0022 : 32'h0000_0021, 4 << (2 * i));
	end
	bus(1'b1, `RRC_ADDR_PROTECT, 32'h0000_1234);
	bus(1'b0, `RRC_ADDR_PROTECT, 32'h0000_0000);
	chk("relock", rd, 32'h0000_0000);
	bus(1'b1, `RRC_ADDR_REGCTRL, 32'h0000_0021);
	repeat (4) @(negedge clk_sys);
	chk("nostop", {sysClkStop, voltageModeLow}, 2'b01);
	for (i = 0; i < 9; i++) begin
		ksel = 4'($urandom_range(15, 1));
		bus(1'b1, `RRC_ADDR_RSTCTRL, {ksel, 4'h7} | (i == 8) << 3);
		src <= (i < 8) ? 8'h01 << i : 8'h00;
		seen = 1'b0;
		hold(i == 8 ? 10 : 60, seen);
		chk("hreq", seen, 1);
		src <= 8'h00;
		relwait(c);
		chk("hrel", c >= (i == 8 ? 8 : 20) && c <= 80, 1);
	end
	bus(1'b1, `RRC_ADDR_RSTCTRL, 32'h0000_00F0);
	src <= 8'hF0;
	seen = 1'b0;
	hold(20, seen);
	src <= 8'hB0;
	hold(60, seen);
	src <= 8'h00;
	chk("nores", seen, 0);
	n = $urandom_range(255, 1);
	bus(1'b1, `RRC_ADDR_SOFTRST, n);
	repeat (2) @(negedge clk_sys);
	chk("soft", softResetOut, n);
	bus(1'b1, `RRC_ADDR_SOFTRST, 32'h0000_0000);
	repeat (2) @(negedge clk_sys);
	chk("softrel", softResetOut, 0);
	@(posedge clk_sys);
	moduleEnable <= 8'h24;
	repeat (2) @(negedge clk_sys);
	chk("menpulse", softResetOut, 8'h04);
	@(negedge clk_sys);
	chk("menend", softResetOut, 0);
	final_report();
end
endmodule // rrc_reset_regulator_tb
